/* sis_int_source_map.vh */
`ifndef SIS_INT_SOURCE_MAP_VH
`define SIS_INT_SOURCE_MAP_VH

// register offsets on the internal register port
`define SIS_ADDR_DATA_STATUS 8'h00
`define SIS_ADDR_FIFO_STATUS 8'h00
`define SIS_ADDR_P_OUT_MSB 8'h01
`define SIS_ADDR_P_OUT_CSB 8'h02
`define SIS_ADDR_P_OUT_LSB 8'h03
`define SIS_ADDR_T_OUT_MSB 8'h04
`define SIS_ADDR_T_OUT_LSB 8'h05
`define SIS_ADDR_INT_SOURCE 8'h12

// status byte layout
`define SIS_BIT_DRDY 7
`define SIS_BIT_FIFO 6
`define SIS_BIT_PW 5
`define SIS_BIT_TW 4
`define SIS_BIT_PTH 3
`define SIS_BIT_TTH 2
`define SIS_BIT_PCHG 1
`define SIS_BIT_TCHG 0
`define SIS_STATUS_RESET 8'h00
`define SIS_PRESSURE_BITS 8'h2A
`define SIS_TEMPERATURE_BITS 8'h15

// fifo event levels
`define SIS_FIFO_FULL_COUNT 6'h20
`define SIS_WMRK_OFF 6'h00

// bus and count widths
`define SIS_ADDR_W 8
`define SIS_DATA_W 8
`define SIS_FCNT_W 6

`endif

/* sis_level_monitor.v */
`timescale 1ns/1ps
`default_nettype none

module sis_level_monitor #(
  parameter W = 16
) (
  // clock and reset
  input wire sys_clk,
  input wire rstn,
  // measurement and levels
  input wire sample_stb,
  input wire [W-1:0] meas,
  input wire [W-1:0] target,
  input wire [W-1:0] window,
  // events
  output reg in_window_reg,
  output reg cross_reg
);

  // one extra bit so target plus window never wraps
  wire [W:0] meas_x;
  wire [W:0] prev_x;
  wire [W:0] center;
  wire [W:0] upper;
  wire [W:0] lower;
  wire window_on;
  wire in_window_next;
  wire cross_center;
  wire cross_outer;
  wire cross_next;
  reg [W-1:0] prev_reg;
  reg prev_valid_reg;

  function above;
    input [W:0] value;
    input [W:0] level;
    begin
      above = (value >= level);
    end
  endfunction

  assign meas_x = {1'b0, meas};
  assign prev_x = {1'b0, prev_reg};
  assign center = {1'b0, target};
  assign upper = {1'b0, target} + {1'b0, window};
  // clamp at zero rather than wrapping below the range
  assign lower = (target > window) ? {1'b0, target - window} : {(W+1){1'b0}};
  assign window_on = |window;

  assign in_window_next = window_on && above(meas_x, lower) && !above(meas_x, upper + 1'b1);
  // both samples on opposite sides of a level
  assign cross_center = prev_valid_reg && (above(prev_x, center) != above(meas_x, center));
  assign cross_outer = prev_valid_reg && window_on &&
    ((above(prev_x, upper) != above(meas_x, upper)) ||
     (above(prev_x, lower) != above(meas_x, lower)));
  assign cross_next = cross_center || cross_outer;

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prev_reg <= {W{1'b0}};
      prev_valid_reg <= 1'b0;
      in_window_reg <= 1'b0;
      cross_reg <= 1'b0;
    end else if (sample_stb) begin
      prev_reg <= meas;
      prev_valid_reg <= 1'b1;
      in_window_reg <= in_window_next;
      cross_reg <= cross_next;
    end else begin
      cross_reg <= 1'b0;
    end
  end

endmodule // sis_level_monitor

`default_nettype wire

/* sis_int_source.v */
`timescale 1ns/1ps
`default_nettype none
`include "sis_int_source_map.vh"

module sis_int_source #(
  parameter P_W = 16,
  parameter T_W = 12,
  parameter FCNT_W = `SIS_FCNT_W
) (
  // clock and reset
  input wire sys_clk,
  input wire rstn,
  // register port from the serial slave
  input wire reg_rd_stb,
  input wire reg_wr_stb,
  input wire [`SIS_ADDR_W-1:0] reg_addr,
  output reg [`SIS_DATA_W-1:0] reg_rdata_reg,
  output reg reg_hit_reg,
  output reg reg_ack_reg,
  // data ready sources
  input wire new_data_flag,
  input wire data_overwrite_flag,
  input wire data_ready_int_en,
  // fifo sources
  input wire fifo_enabled,
  input wire [FCNT_W-1:0] fifo_sample_count,
  input wire [FCNT_W-1:0] fifo_watermark_count,
  // pressure measurement and alert levels
  input wire p_sample_stb,
  input wire [P_W-1:0] p_meas,
  input wire [P_W-1:0] p_target,
  input wire [P_W-1:0] p_window,
  // temperature measurement and alert levels
  input wire t_sample_stb,
  input wire [T_W-1:0] t_meas,
  input wire [T_W-1:0] t_target,
  input wire [T_W-1:0] t_window,
  // change events
  input wire pressure_change_event,
  input wire temperature_change_event,
  // status view
  output reg fifo_overflow_flag,
  output wire [`SIS_DATA_W-1:0] int_source_status,
  output wire data_ready_event_bit,
  output wire fifo_event_bit,
  output wire pressure_window_event_bit,
  output wire temperature_window_event_bit,
  output wire pressure_threshold_event_bit,
  output wire temperature_threshold_event_bit,
  output wire pressure_change_event_bit,
  output wire temperature_change_event_bit,
  output wire int_source_any
);

  // event source levels, one per status bit
  wire [`SIS_DATA_W-1:0] src;
  wire [`SIS_DATA_W-1:0] rise;
  wire [`SIS_DATA_W-1:0] clr;
  wire [`SIS_DATA_W-1:0] status_next;
  reg [`SIS_DATA_W-1:0] src_d_reg;
  reg [`SIS_DATA_W-1:0] status_reg;

  wire p_in_window;
  wire t_in_window;
  wire p_cross;
  wire t_cross;
  wire fifo_ovf;
  wire fifo_wmrk;

  // read decode
  wire rd_data_status;
  wire rd_fifo_status;
  wire rd_p_out;
  wire rd_t_out;
  wire rd_int_source;
  wire drdy_clear;
  wire out_read;
  reg [1:0] drdy_state_reg;
  reg [1:0] drdy_state_next;

  // data ready clear sequence, one-hot
  localparam DRDY_WAIT_STATUS = 2'h1;
  localparam DRDY_WAIT_OUTPUT = 2'h2;

  // per-generator fifo edges: watermark running into overflow still counts
  wire fifo_rise;
  wire [`SIS_DATA_W-1:0] set_bits;
  reg fifo_wmrk_d_reg;

  function is_p_out;
    input [`SIS_ADDR_W-1:0] a;
    begin
      is_p_out = (a == `SIS_ADDR_P_OUT_MSB) || (a == `SIS_ADDR_P_OUT_CSB) ||
        (a == `SIS_ADDR_P_OUT_LSB);
    end
  endfunction

  function is_t_out;
    input [`SIS_ADDR_W-1:0] a;
    begin
      is_t_out = (a == `SIS_ADDR_T_OUT_MSB) || (a == `SIS_ADDR_T_OUT_LSB);
    end
  endfunction

  // window and crossing detectors
  sis_level_monitor #(
    .W(P_W)
  ) u_p_mon (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .sample_stb(p_sample_stb),
    .meas(p_meas),
    .target(p_target),
    .window(p_window),
    .in_window_reg(p_in_window),
    .cross_reg(p_cross)
  );

  sis_level_monitor #(
    .W(T_W)
  ) u_t_mon (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .sample_stb(t_sample_stb),
    .meas(t_meas),
    .target(t_target),
    .window(t_window),
    .in_window_reg(t_in_window),
    .cross_reg(t_cross)
  );

  // fifo event sources
  assign fifo_ovf = (fifo_sample_count == `SIS_FIFO_FULL_COUNT);
  assign fifo_wmrk = (fifo_watermark_count != `SIS_WMRK_OFF) &&
    (fifo_sample_count == fifo_watermark_count);
  // the overflow flag doubles as the overflow history
  assign fifo_rise = (fifo_ovf && !fifo_overflow_flag) || (fifo_wmrk && !fifo_wmrk_d_reg);

  // source map onto the status byte
  assign src[`SIS_BIT_DRDY] = data_ready_int_en && (new_data_flag || data_overwrite_flag);
  assign src[`SIS_BIT_FIFO] = fifo_ovf || fifo_wmrk;
  assign src[`SIS_BIT_PW] = p_in_window;
  assign src[`SIS_BIT_TW] = t_in_window;
  assign src[`SIS_BIT_PTH] = p_cross;
  assign src[`SIS_BIT_TTH] = t_cross;
  assign src[`SIS_BIT_PCHG] = pressure_change_event;
  assign src[`SIS_BIT_TCHG] = temperature_change_event;

  // offset 0x00 is the fifo status while the fifo runs, else data status
  assign rd_data_status = reg_rd_stb && !fifo_enabled && (reg_addr == `SIS_ADDR_DATA_STATUS);
  assign rd_fifo_status = reg_rd_stb && fifo_enabled && (reg_addr == `SIS_ADDR_FIFO_STATUS);
  assign rd_p_out = reg_rd_stb && is_p_out(reg_addr);
  assign rd_t_out = reg_rd_stb && is_t_out(reg_addr);
  assign rd_int_source = reg_rd_stb && (reg_addr == `SIS_ADDR_INT_SOURCE);

  // data ready needs both reads, status first, then any output byte
  assign out_read = rd_p_out || rd_t_out;
  assign drdy_clear = (drdy_state_reg == DRDY_WAIT_OUTPUT) && out_read;

  always @* begin
    drdy_state_next = drdy_state_reg;
    case (drdy_state_reg)
      DRDY_WAIT_STATUS: begin
        if (rd_data_status) begin
          drdy_state_next = DRDY_WAIT_OUTPUT;
        end
      end
      DRDY_WAIT_OUTPUT: begin
        if (out_read) begin
          drdy_state_next = DRDY_WAIT_STATUS;
        end
      end
      default: begin
        drdy_state_next = DRDY_WAIT_STATUS;
      end
    endcase
  end

  // clear vector per bit
  assign clr[`SIS_BIT_DRDY] = drdy_clear;
  assign clr[`SIS_BIT_FIFO] = rd_fifo_status;
  assign clr[`SIS_BIT_PW] = rd_p_out;
  assign clr[`SIS_BIT_TW] = rd_t_out;
  assign clr[`SIS_BIT_PTH] = rd_p_out;
  assign clr[`SIS_BIT_TTH] = rd_t_out;
  assign clr[`SIS_BIT_PCHG] = rd_p_out;
  assign clr[`SIS_BIT_TCHG] = rd_t_out;

  // set vector per bit
  assign set_bits[`SIS_BIT_DRDY] = rise[`SIS_BIT_DRDY];
  assign set_bits[`SIS_BIT_FIFO] = rise[`SIS_BIT_FIFO] || fifo_rise;
  assign set_bits[`SIS_BIT_PW] = rise[`SIS_BIT_PW];
  assign set_bits[`SIS_BIT_TW] = rise[`SIS_BIT_TW];
  assign set_bits[`SIS_BIT_PTH] = rise[`SIS_BIT_PTH];
  assign set_bits[`SIS_BIT_TTH] = rise[`SIS_BIT_TTH];
  assign set_bits[`SIS_BIT_PCHG] = rise[`SIS_BIT_PCHG];
  assign set_bits[`SIS_BIT_TCHG] = rise[`SIS_BIT_TCHG];

  // sticky bits: an edge landing on the clearing read still sets
  genvar i;
  generate
    for (i = 0; i < `SIS_DATA_W; i = i + 1) begin : g_bit
      assign rise[i] = src[i] && !src_d_reg[i];
      assign status_next[i] = set_bits[i] || (status_reg[i] && !clr[i]);
    end
  endgenerate

  // writes carry no path into status_reg at all
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      src_d_reg <= `SIS_STATUS_RESET;
      status_reg <= `SIS_STATUS_RESET;
      drdy_state_reg <= DRDY_WAIT_STATUS;
      fifo_wmrk_d_reg <= 1'b0;
      fifo_overflow_flag <= 1'b0;
    end else begin
      src_d_reg <= src;
      status_reg <= status_next;
      drdy_state_reg <= drdy_state_next;
      fifo_wmrk_d_reg <= fifo_wmrk;
      fifo_overflow_flag <= fifo_ovf;
    end
  end

  // register readback, one cycle after the strobe
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_reg <= `SIS_STATUS_RESET;
      reg_hit_reg <= 1'b0;
      reg_ack_reg <= 1'b0;
    end else begin
      reg_ack_reg <= reg_rd_stb || reg_wr_stb;
      reg_hit_reg <= (reg_rd_stb || reg_wr_stb) && (reg_addr == `SIS_ADDR_INT_SOURCE);
      if (rd_int_source) begin
        reg_rdata_reg <= status_reg;
      end else if (reg_rd_stb) begin
        reg_rdata_reg <= `SIS_STATUS_RESET;
      end
    end
  end

  // status view
  assign int_source_status = status_reg;
  assign data_ready_event_bit = status_reg[`SIS_BIT_DRDY];
  assign fifo_event_bit = status_reg[`SIS_BIT_FIFO];
  assign pressure_window_event_bit = status_reg[`SIS_BIT_PW];
  assign temperature_window_event_bit = status_reg[`SIS_BIT_TW];
  assign pressure_threshold_event_bit = status_reg[`SIS_BIT_PTH];
  assign temperature_threshold_event_bit = status_reg[`SIS_BIT_TTH];
  assign pressure_change_event_bit = status_reg[`SIS_BIT_PCHG];
  assign temperature_change_event_bit = status_reg[`SIS_BIT_TCHG];
  assign int_source_any = |status_reg;

endmodule // sis_int_source

`default_nettype wire

/* sis_int_source_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module sis_int_source_chk #(
  parameter FCNT_W = 6
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // register port
  input wire logic reg_rd_stb,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata_reg,
  input wire logic reg_hit_reg,
  // sources
  input wire logic new_data_flag,
  input wire logic data_overwrite_flag,
  input wire logic data_ready_int_en,
  input wire logic [FCNT_W-1:0] fifo_sample_count,
  input wire logic pressure_change_event,
  input wire logic temperature_change_event,
  // status
  input wire logic fifo_overflow_flag,
  input wire logic [7:0] int_source_status,
  input wire logic data_ready_event_bit,
  input wire logic fifo_event_bit,
  input wire logic pressure_window_event_bit,
  input wire logic temperature_window_event_bit,
  input wire logic pressure_threshold_event_bit,
  input wire logic temperature_threshold_event_bit,
  input wire logic pressure_change_event_bit,
  input wire logic temperature_change_event_bit,
  input wire logic int_source_any
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_rdat;
    reg_rd_stb && reg_addr == 8'h12 |=> reg_hit_reg && reg_rdata_reg == $past(int_source_status);
  endproperty
  a_rdat: assert property (p_rdat) else $error("status read wrong");
  // a clear only lands after the edge that took the read
  property p_hold;
    !$past(reg_rd_stb) |-> (int_source_status & $past(int_source_status)) == $past(int_source_status);
  endproperty
  a_hold: assert property (p_hold) else $error("bit lost without read");
  property p_pchg;
    $rose(pressure_change_event) |=> pressure_change_event_bit;
  endproperty
  a_pchg: assert property (p_pchg) else $error("pressure change missed");
  property p_tchg;
    $rose(temperature_change_event) |=> temperature_change_event_bit;
  endproperty
  a_tchg: assert property (p_tchg) else $error("temperature change missed");
  property p_drdy;
    data_ready_int_en && $rose(new_data_flag || data_overwrite_flag) |=> data_ready_event_bit;
  endproperty
  a_drdy: assert property (p_drdy) else $error("data ready missed");
  property p_ovf;
    fifo_sample_count == 6'h20 |=> fifo_overflow_flag;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow missed");
  property p_fovf;
    $rose(fifo_overflow_flag) |-> fifo_event_bit;
  endproperty
  a_fovf: assert property (p_fovf) else $error("fifo bit missed");
  property p_any;
    int_source_any == |int_source_status;
  endproperty
  a_any: assert property (p_any) else $error("summary wrong");
  property p_map;
    int_source_status == {data_ready_event_bit, fifo_event_bit, pressure_window_event_bit,
      temperature_window_event_bit, pressure_threshold_event_bit, temperature_threshold_event_bit,
      pressure_change_event_bit, temperature_change_event_bit};
  endproperty
  a_map: assert property (p_map) else $error("bit view wrong");
endmodule // sis_int_source_chk
bind sis_int_source sis_int_source_chk #(.FCNT_W(FCNT_W)) sis_int_source_chk_inst (.sys_clk, .rstn,
  .reg_rd_stb, .reg_addr, .reg_rdata_reg, .reg_hit_reg, .new_data_flag, .data_overwrite_flag,
  .data_ready_int_en, .fifo_sample_count, .pressure_change_event, .temperature_change_event,
  .fifo_overflow_flag, .int_source_status, .data_ready_event_bit, .fifo_event_bit,
  .pressure_window_event_bit, .temperature_window_event_bit, .pressure_threshold_event_bit,
  .temperature_threshold_event_bit, .pressure_change_event_bit, .temperature_change_event_bit, .int_source_any);
`default_nettype wire

/* sis_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sis_host_model (
  // clock
  input wire logic sys_clk,
  // register strobes
  output logic rd,
  output logic wr,
  output logic [7:0] addr
);
  initial begin
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
  end
  // address inverted once released so no stale value lingers
  task automatic acc(input logic w, input logic [7:0] a);
    @(negedge sys_clk);
    rd = !w;
    wr = w;
    addr = a;
    @(negedge sys_clk);
    rd = 1'b0;
    wr = 1'b0;
    addr = ~a;
  endtask
  // status read first, then one output byte
  task automatic drdy_clr(input logic [7:0] a);
    acc(1'b0, 8'h00);
    acc(1'b0, a);
  endtask
endmodule // sis_host_model
`default_nettype wire

/* sis_int_source_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sis_int_source_tb_top;
  logic sys_clk = 1'b0, rstn = 1'b0, rd, wr, nd = 0, ow = 0, en = 0, fe = 0, pst = 0, tst = 0, pc = 0, tc = 0, ovf;
  logic [7:0] addr, rdat, st;
  logic ack, hit;
  logic [5:0] fc = 6'h00, fw = 6'h00;
  logic [15:0] pm = 16'h0000, pt = 16'h0000, pw = 16'h0000;
  logic [11:0] tm = 12'h000, tt = 12'h000, tw = 12'h000;
  int mismatches = 0, checks_done = 0, cyc = 0;
  always #12.5 sys_clk = ~sys_clk;
  sis_host_model sis_host_model_inst (.sys_clk, .rd, .wr, .addr);
  sis_int_source sis_int_source_inst (.sys_clk, .rstn, .reg_rd_stb(rd), .reg_wr_stb(wr), .reg_addr(addr),
    .reg_rdata_reg(rdat), .reg_hit_reg(hit), .reg_ack_reg(ack), .new_data_flag(nd), .data_overwrite_flag(ow),
    .data_ready_int_en(en), .fifo_enabled(fe), .fifo_sample_count(fc), .fifo_watermark_count(fw),
    .p_sample_stb(pst), .p_meas(pm), .p_target(pt), .p_window(pw), .t_sample_stb(tst), .t_meas(tm),
    .t_target(tt), .t_window(tw), .pressure_change_event(pc), .temperature_change_event(tc),
    .fifo_overflow_flag(ovf), .int_source_status(st), .data_ready_event_bit(), .fifo_event_bit(),
    .pressure_window_event_bit(), .temperature_window_event_bit(), .pressure_threshold_event_bit(),
    .temperature_threshold_event_bit(), .pressure_change_event_bit(), .temperature_change_event_bit(),
    .int_source_any());
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // ack and hit stand for the one cycle after the strobe
  task automatic rg(logic w, logic [7:0] a);
    sis_host_model_inst.acc(w, a);
    chk("ack", 8'h01, {7'h00, ack});
    chk("hit", {7'h00, a == 8'h12}, {7'h00, hit});
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // window bits lag the strobe by two cycles
  task automatic smp(logic t, logic [15:0] m);
    @(negedge sys_clk);
    if (t) tm = m[11:0];
    else pm = m;
    tst = t;
    pst = !t;
    tick(1);
    tst = 1'b0;
    pst = 1'b0;
    tick(2);
  endtask
  task automatic t_rst();
    chk("status", 8'h00, st);
    rg(1'b0, 8'h12);
    chk("rdata", 8'h00, rdat);
  endtask
  task automatic t_chg();
    tick(1);
    pc = 1'b1;
    tc = 1'b1;
    tick(1);
    chk("chg", 8'h03, st);
    rg(1'b0, 8'h12);
    chk("rd12", 8'h03, rdat);
    rg(1'b1, 8'h12);
    chk("wr", 8'h03, st);
    chk("wrd", 8'h03, rdat);
    rg(1'b0, 8'h01);
    chk("pclr", 8'h01, st);
    rg(1'b0, 8'h04);
    tick(3);
    chk("held", 8'h00, st);
    pc = 1'b0;
    tc = 1'b0;
  endtask
  task automatic t_drdy();
    en = 1'b1;
    nd = 1'b1;
    tick(1);
    chk("drdy", 8'h80, st);
    rg(1'b0, 8'h01);
    chk("drdy1", 8'h80, st);
    sis_host_model_inst.drdy_clr(8'h01);
    chk("drdy2", 8'h00, st);
    nd = 1'b0;
    tick(1);
    ow = 1'b1;
    tick(1);
    chk("ovw", 8'h80, st);
    sis_host_model_inst.drdy_clr(8'h05);
    chk("drdy3", 8'h00, st);
    ow = 1'b0;
    en = 1'b0;
    nd = 1'b1;
    tick(2);
    chk("drdyoff", 8'h00, st);
    nd = 1'b0;
  endtask
  task automatic t_fifo();
    fe = 1'b1;
    fw = 6'h05;
    fc = 6'h04;
    tick(1);
    fc = 6'h05;
    tick(1);
    chk("wmrk", 8'h40, st);
    rg(1'b0, 8'h00);
    chk("fclr", 8'h00, st);
    fw = 6'h00;
    fc = 6'h00;
    tick(2);
    chk("wm0", 8'h00, st);
    fc = 6'h20;
    tick(2);
    chk("ovf", 8'h01, {7'h00, ovf});
    chk("fovf", 8'h40, st);
    rg(1'b0, 8'h00);
    fc = 6'h00;
    fe = 1'b0;
  endtask
  task automatic t_win();
    pt = 16'h0064;
    smp(1'b0, 16'h005A);
    smp(1'b0, 16'h006E);
    chk("pth0", 8'h08, st & 8'h2A);
    smp(1'b0, 16'h0064);
    chk("pw0", 8'h08, st & 8'h2A);
    rg(1'b0, 8'h01);
    pw = 16'h000A;
    smp(1'b0, 16'h0068);
    chk("pwin", 8'h20, st & 8'h20);
    rg(1'b0, 8'h01);
    smp(1'b0, 16'h006A);
    chk("pquiet", 8'h00, st & 8'h2A);
    smp(1'b0, 16'h005F);
    chk("pctr", 8'h08, st & 8'h2A);
    rg(1'b0, 8'h01);
    smp(1'b0, 16'h0055);
    chk("plow", 8'h08, st & 8'h2A);
    tt = 12'h032;
    tw = 12'h005;
    smp(1'b1, 16'h0034);
    chk("twin", 8'h10, st & 8'h15);
    smp(1'b1, 16'h0028);
    chk("tth", 8'h04, st & 8'h04);
  endtask
  // mid-run reset with a source still high: bit returns at first edge
  task automatic t_rst2();
    pc = 1'b1;
    tick(1);
    rstn = 1'b0;
    tick(2);
    chk("rst", 8'h00, st);
    rstn = 1'b1;
    tick(1);
    chk("rel", 8'h02, st);
    rg(1'b0, 8'h01);
    chk("rclr", 8'h00, st);
    pc = 1'b0;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // generous ceiling, the full run needs about ninety cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rstn = 1'b1;
    t_rst();
    t_chg();
    t_drdy();
    t_fifo();
    t_win();
    t_rst2();
    close_out();
  end
endmodule // sis_int_source_tb_top
`default_nettype wire
